/* hdl/fofc_config.sv */
// Flat interrupt and fast offset compensation configuration bank on Avalon-MM
//
// Functional notes
// - Flat configuration lives in two consecutive bytes from 0x67: angle, then hold/hysteresis.
// - Six-bit flat threshold angle in bits 5:0, 0 to 44.8 degrees, resets to 8.
// - Flat interrupt only after flat state stable for 0, 640, 1280 or 2560 ms.
// - Hysteresis in bits 2:0 of second flat byte drives detection, resets to 1.
// - Offset compensation byte at 0x69 is read-write and resets to zero.
// - Bit 6 of compensation byte includes all three gyro axes.
// - Accel x target bits 5:4: off, +1 g, -1 g, 0 g.
// - Accel y target bits 3:2: off, +1 g, -1 g, 0 g.
// - Accel z target bits 1:0: off, +1 g, -1 g, 0 g.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
module fofc_config
  import fofc_pkg::*;
#(
  parameter int CLK_PER_MS = FOFC_CLK_PER_MS
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [FOFC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic flat_state,
  output logic [FOFC_THETA_W-1:0] flat_theta,
  output logic [FOFC_HYST_W-1:0] level_hysteresis,
  output logic [FOFC_HOLD_W-1:0] flat_hold_code,
  output logic flat_int,
  output logic [2:0] gyr_comp_en,
  output logic [2:0] acc_comp_en,
  output logic [2:0] acc_target_plus,
  output logic [2:0] acc_target_minus
);
  localparam int TICK_W = $clog2(CLK_PER_MS + 1);

  // Elaboration check on the tick divider
  if (CLK_PER_MS < 1) begin : g_bad_div
    $error("CLK_PER_MS must be at least one");
  end

  logic [7:0] flat_threshold_angle;
  logic [7:0] flat_hold_and_hysteresis;
  logic [7:0] offset_comp_config;
  logic ack;
  logic access;
  logic wr_go;
  logic [7:0] reg_index;
  logic [7:0] next_rdata;
  logic [TICK_W-1:0] tick_cnt;
  logic ms_tick;
  logic [FOFC_MS_W-1:0] hold_ms;

  fofc_hold_if hold ();

  // Decode a hold code into milliseconds
  function automatic logic [FOFC_MS_W-1:0] hold_code_ms(input logic [1:0] code);
    logic [FOFC_MS_W-1:0] ms;
    ms = FOFC_MS_2560;
    if (code == FOFC_HOLD_0MS) begin
      ms = FOFC_MS_ZERO;
    end else if (code == FOFC_HOLD_640MS) begin
      ms = FOFC_MS_640;
    end else if (code == FOFC_HOLD_1280MS) begin
      ms = FOFC_MS_1280;
    end
    return ms;
  endfunction

  // Decode an axis target code into enable, plus and minus flags
  function automatic logic [2:0] acc_decode(input logic [1:0] code);
    logic [2:0] d;
    d = 3'h0;
    case (fofc_acc_target_t'(code))
      FOFC_ACC_PLUS_1G: d = 3'h3;
      FOFC_ACC_MINUS_1G: d = 3'h5;
      FOFC_ACC_ZERO_G: d = 3'h1;
      default: d = 3'h0;
    endcase
    return d;
  endfunction

  // Bus address to register index; address bits below FOFC_BYTE_SHIFT are ignored, so unaligned addresses map too
  assign reg_index = avs_address[FOFC_BYTE_SHIFT +: 8];
  assign access = avs_read || avs_write;

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = access && !ack;
  assign wr_go = avs_write && ack && avs_byteenable[0];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= access && !ack;
    end
  end

  // Register writes; reserved bits are kept so software reads them back
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flat_threshold_angle <= FOFC_RST_FLAT_THRESHOLD;
      flat_hold_and_hysteresis <= FOFC_RST_FLAT_HOLD_HYST;
      offset_comp_config <= FOFC_RST_OFFSET_COMP;
    end else if (wr_go) begin
      if (reg_index == FOFC_IDX_FLAT_THRESHOLD) begin
        flat_threshold_angle <= avs_writedata[7:0];
      end else if (reg_index == FOFC_IDX_FLAT_HOLD_HYST) begin
        flat_hold_and_hysteresis <= avs_writedata[7:0];
      end else if (reg_index == FOFC_IDX_OFFSET_COMP) begin
        offset_comp_config <= avs_writedata[7:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_index == FOFC_IDX_FLAT_THRESHOLD) begin
      next_rdata = flat_threshold_angle;
    end else if (reg_index == FOFC_IDX_FLAT_HOLD_HYST) begin
      next_rdata = flat_hold_and_hysteresis;
    end else if (reg_index == FOFC_IDX_OFFSET_COMP) begin
      next_rdata = offset_comp_config;
    end else if (reg_index == FOFC_IDX_FLAT_STATUS) begin
      next_rdata[FOFC_STAT_LEVEL_BIT] = hold.level;
      next_rdata[FOFC_STAT_PEND_BIT] = hold.pending;
    end
  end

  // Read data captured in the wait cycle, standing at the release edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // Millisecond tick; slow enough that the hold counter stays small
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= '0;
      ms_tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(CLK_PER_MS - 1)) begin
      tick_cnt <= '0;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick <= 1'b0;
    end
  end

  // Field outputs to the detection and compensation engines
  assign flat_theta = flat_threshold_angle[FOFC_THETA_LSB +: FOFC_THETA_W];
  assign level_hysteresis = flat_hold_and_hysteresis[FOFC_HYST_LSB +: FOFC_HYST_W];
  assign flat_hold_code = flat_hold_and_hysteresis[FOFC_HOLD_LSB +: FOFC_HOLD_W];
  assign hold_ms = hold_code_ms(flat_hold_code);
  assign gyr_comp_en = {3{offset_comp_config[FOFC_GYR_EN_BIT]}};

  // Per-axis accelerometer target decode, index 0 is z, 2 is x
  for (genvar i = 0; i < 3; i++) begin : g_axis
    localparam int LSB = (i == 0) ? FOFC_ACC_Z_LSB : (i == 1) ? FOFC_ACC_Y_LSB : FOFC_ACC_X_LSB;
    logic [2:0] dec;
    assign dec = acc_decode(offset_comp_config[LSB +: FOFC_ACC_W]);
    assign acc_comp_en[i] = dec[0];
    assign acc_target_plus[i] = dec[1];
    assign acc_target_minus[i] = dec[2];
  end

  // Hold timer connection
  assign hold.flat_state = flat_state;
  assign hold.hold_ms = hold_ms;
  assign hold.ms_tick = ms_tick;
  assign flat_int = hold.flat_int;

  fofc_flat_hold u_hold (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .hold(hold.tmr)
  );

  // Writes to the first flat byte land in the threshold angle
  property p_theta_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_FLAT_THRESHOLD)
        |=> flat_theta == $past(avs_writedata[5:0]);
  endproperty
  a_theta_write: assert property (p_theta_write) else $error("theta not written");

  // Second flat byte sits one index above the first
  property p_hold_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_FLAT_HOLD_HYST)
        |=> flat_hold_code == $past(avs_writedata[5:4]) && $stable(flat_theta);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold byte wrong");

  // Threshold holds its value without a write to it
  property p_theta_stable;
    @(posedge clk_sys) disable iff (!arst_n)
      !(wr_go && reg_index == FOFC_IDX_FLAT_THRESHOLD) |=> $stable(flat_theta);
  endproperty
  a_theta_stable: assert property (p_theta_stable) else $error("theta changed");

  // Hold time in ms matches the code
  property p_hold_map;
    @(posedge clk_sys) disable iff (!arst_n)
      hold_ms == ((flat_hold_code == 2'h0) ? 12'h000 : (flat_hold_code == 2'h1) ? 12'h280 :
                  (flat_hold_code == 2'h2) ? 12'h500 : 12'hA00);
  endproperty
  a_hold_map: assert property (p_hold_map) else $error("hold map wrong");

  // Bit 3 of the second flat byte never reaches the hysteresis
  property p_hyst_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_FLAT_HOLD_HYST)
        |=> level_hysteresis == $past(avs_writedata[2:0]);
  endproperty
  a_hyst_write: assert property (p_hyst_write) else $error("hysteresis wrong");

  // Reading the compensation byte returns what was written
  property p_comp_readback;
    @(posedge clk_sys) disable iff (!arst_n)
      (avs_read && !ack && reg_index == FOFC_IDX_OFFSET_COMP)
        |=> !avs_waitrequest && avs_readdata == {24'h00_0000, offset_comp_config};
  endproperty
  a_comp_readback: assert property (p_comp_readback) else $error("comp readback wrong");

  // Gyro enable follows bit 6 one cycle after a write
  property p_gyr_en;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_OFFSET_COMP)
        |=> gyr_comp_en == {3{$past(avs_writedata[6])}};
  endproperty
  a_gyr_en: assert property (p_gyr_en) else $error("gyro enable wrong");

  // X axis: code 10 means minus one g
  property p_acc_x;
    @(posedge clk_sys) disable iff (!arst_n)
      acc_comp_en[2] == (offset_comp_config[5:4] != 2'h0) &&
      acc_target_minus[2] == (offset_comp_config[5:4] == 2'h2);
  endproperty
  a_acc_x: assert property (p_acc_x) else $error("x target wrong");

  // Y axis: code 01 means plus one g
  property p_acc_y;
    @(posedge clk_sys) disable iff (!arst_n)
      acc_comp_en[1] == (offset_comp_config[3:2] != 2'h0) &&
      acc_target_plus[1] == (offset_comp_config[3:2] == 2'h1);
  endproperty
  a_acc_y: assert property (p_acc_y) else $error("y target wrong");

  // Z axis: code 11 is zero g, neither plus nor minus
  property p_acc_z;
    @(posedge clk_sys) disable iff (!arst_n)
      (offset_comp_config[1:0] == 2'h3)
        |-> acc_comp_en[0] && !acc_target_plus[0] && !acc_target_minus[0];
  endproperty
  a_acc_z: assert property (p_acc_z) else $error("z target wrong");

  // Exactly one wait cycle per request
  property p_one_wait;
    @(posedge clk_sys) disable iff (!arst_n)
      (access && !ack) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");

  // Compensation byte takes the whole written byte, threshold untouched
  property p_comp_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_OFFSET_COMP)
        |=> offset_comp_config == $past(avs_writedata[7:0]) && $stable(flat_theta);
  endproperty
  a_comp_write: assert property (p_comp_write) else $error("comp byte wrong");

  // Reserved bits of the first flat byte are stored as written
  property p_reserved_kept;
    @(posedge clk_sys) disable iff (!arst_n)
      (wr_go && reg_index == FOFC_IDX_FLAT_THRESHOLD)
        |=> flat_threshold_angle == $past(avs_writedata[7:0]);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept) else $error("reserved bits lost");

  // A write with byte lane 0 off leaves every register alone
  property p_masked_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (avs_write && ack && !avs_byteenable[0])
        |=> $stable(flat_threshold_angle) && $stable(flat_hold_and_hysteresis) &&
            $stable(offset_comp_config);
  endproperty
  a_masked_write: assert property (p_masked_write) else $error("masked write landed");

  // A read never disturbs the stored bytes
  property p_read_quiet;
    @(posedge clk_sys) disable iff (!arst_n)
      avs_read
        |=> $stable(flat_threshold_angle) && $stable(flat_hold_and_hysteresis) &&
            $stable(offset_comp_config);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed a register");

  // Unmapped indices read as zero
  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (!arst_n)
      (avs_read && !ack && reg_index != FOFC_IDX_FLAT_THRESHOLD &&
       reg_index != FOFC_IDX_FLAT_HOLD_HYST && reg_index != FOFC_IDX_OFFSET_COMP &&
       reg_index != FOFC_IDX_FLAT_STATUS) |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // Status read shows the stored level and the pending hold
  property p_status_read;
    @(posedge clk_sys) disable iff (!arst_n)
      (avs_read && !ack && reg_index == FOFC_IDX_FLAT_STATUS)
        |=> avs_readdata[FOFC_STAT_LEVEL_BIT] == $past(hold.level) &&
            avs_readdata[FOFC_STAT_PEND_BIT] == $past(hold.pending);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // X axis: code 01 is plus one g
  property p_acc_x_plus;
    @(posedge clk_sys) disable iff (!arst_n)
      acc_target_plus[2] == (offset_comp_config[5:4] == 2'h1);
  endproperty
  a_acc_x_plus: assert property (p_acc_x_plus) else $error("x plus wrong");

  // Y axis: code 10 is minus one g
  property p_acc_y_minus;
    @(posedge clk_sys) disable iff (!arst_n)
      acc_target_minus[1] == (offset_comp_config[3:2] == 2'h2);
  endproperty
  a_acc_y_minus: assert property (p_acc_y_minus) else $error("y minus wrong");

  // Z axis: plus and minus flags follow codes 01 and 10
  property p_acc_z_sign;
    @(posedge clk_sys) disable iff (!arst_n)
      acc_target_plus[0] == (offset_comp_config[1:0] == 2'h1) &&
      acc_target_minus[0] == (offset_comp_config[1:0] == 2'h2);
  endproperty
  a_acc_z_sign: assert property (p_acc_z_sign) else $error("z sign wrong");

  // Main scenarios
  c_write_comp: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr_go && reg_index == FOFC_IDX_OFFSET_COMP);
  c_read_status: cover property (@(posedge clk_sys) disable iff (!arst_n)
    avs_read && ack && reg_index == FOFC_IDX_FLAT_STATUS);
  c_flat_irq: cover property (@(posedge clk_sys) disable iff (!arst_n) flat_int);
endmodule

/* hdl/fofc_flat_hold.sv */
// Flat hold timer: flags a flat change once it has stayed stable long enough
`timescale 1ns/10ps
module fofc_flat_hold
  import fofc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  fofc_hold_if.tmr hold
);
  logic [FOFC_MS_W-1:0] ms_cnt;
  logic changed;

  assign changed = hold.flat_state != hold.level;

  // Track the last seen flat level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hold.level <= 1'b0;
    end else begin
      hold.level <= hold.flat_state;
    end
  end

  // Restart on any change; fire once the stable time reaches the hold time
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt <= FOFC_MS_ZERO;
      hold.pending <= 1'b0;
      hold.flat_int <= 1'b0;
    end else begin
      hold.flat_int <= 1'b0;
      if (changed) begin
        ms_cnt <= FOFC_MS_ZERO;
        hold.pending <= 1'b1;
      end else if (hold.pending) begin
        // First tick may land at once, so one extra ms keeps the full hold
        if (hold.hold_ms == FOFC_MS_ZERO || ms_cnt > hold.hold_ms) begin
          hold.flat_int <= 1'b1;
          hold.pending <= 1'b0;
        end else if (hold.ms_tick) begin
          ms_cnt <= ms_cnt + 1'b1;
        end
      end
    end
  end

  // Interrupt only after the counted stable time covers the hold time
  property p_hold_reached;
    @(posedge clk_sys) disable iff (!arst_n)
      $rose(hold.flat_int) |->
        $past(hold.hold_ms) == FOFC_MS_ZERO || $past(ms_cnt) > $past(hold.hold_ms);
  endproperty
  a_hold_reached: assert property (p_hold_reached) else $error("flat irq before hold");

  // A change of the flat level never fires in the next cycle with hold set
  property p_change_restarts;
    @(posedge clk_sys) disable iff (!arst_n)
      (changed && hold.hold_ms != FOFC_MS_ZERO) |=> !hold.flat_int;
  endproperty
  a_change_restarts: assert property (p_change_restarts) else $error("hold not restarted");

  c_flat_int: cover property (@(posedge clk_sys) disable iff (!arst_n) hold.flat_int);
endmodule

/* hdl/fofc_hold_if.sv */
// Link between the register bank and the flat hold timer
`timescale 1ns/10ps
interface fofc_hold_if;
  import fofc_pkg::*;
  logic flat_state;
  logic [FOFC_MS_W-1:0] hold_ms;
  logic ms_tick;
  logic flat_int;
  logic pending;
  logic level;
  modport ctl (output flat_state, output hold_ms, output ms_tick,
               input flat_int, input pending, input level);
  modport tmr (input flat_state, input hold_ms, input ms_tick,
               output flat_int, output pending, output level);
endinterface

/* hdl/fofc_pkg.sv */
// Constants for the flat and offset compensation configuration bank
package fofc_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] FOFC_IDX_FLAT_THRESHOLD = 8'h67;
  localparam logic [7:0] FOFC_IDX_FLAT_HOLD_HYST = 8'h68;
  localparam logic [7:0] FOFC_IDX_OFFSET_COMP = 8'h69;
  localparam logic [7:0] FOFC_IDX_FLAT_STATUS = 8'h70;
  localparam int FOFC_ADDR_W = 10;
  localparam int FOFC_BYTE_SHIFT = 2;

  // Reset values
  localparam logic [7:0] FOFC_RST_FLAT_THRESHOLD = 8'h08;
  localparam logic [7:0] FOFC_RST_FLAT_HOLD_HYST = 8'h11;
  localparam logic [7:0] FOFC_RST_OFFSET_COMP = 8'h00;

  // Field positions
  localparam int FOFC_THETA_LSB = 0;
  localparam int FOFC_THETA_W = 6;
  localparam int FOFC_HYST_LSB = 0;
  localparam int FOFC_HYST_W = 3;
  localparam int FOFC_HOLD_LSB = 4;
  localparam int FOFC_HOLD_W = 2;
  localparam int FOFC_GYR_EN_BIT = 6;
  localparam int FOFC_ACC_X_LSB = 4;
  localparam int FOFC_ACC_Y_LSB = 2;
  localparam int FOFC_ACC_Z_LSB = 0;
  localparam int FOFC_ACC_W = 2;
  localparam int FOFC_STAT_LEVEL_BIT = 0;
  localparam int FOFC_STAT_PEND_BIT = 1;

  // Hold time codes and their durations in milliseconds
  localparam int FOFC_MS_W = 12;
  localparam logic [1:0] FOFC_HOLD_0MS = 2'h0;
  localparam logic [1:0] FOFC_HOLD_640MS = 2'h1;
  localparam logic [1:0] FOFC_HOLD_1280MS = 2'h2;
  localparam logic [FOFC_MS_W-1:0] FOFC_MS_640 = 12'h280;
  localparam logic [FOFC_MS_W-1:0] FOFC_MS_1280 = 12'h500;
  localparam logic [FOFC_MS_W-1:0] FOFC_MS_2560 = 12'hA00;
  localparam logic [FOFC_MS_W-1:0] FOFC_MS_ZERO = 12'h000;

  // Accelerometer compensation target codes
  typedef enum logic [1:0] {
    FOFC_ACC_OFF = 2'h0,
    FOFC_ACC_PLUS_1G = 2'h1,
    FOFC_ACC_MINUS_1G = 2'h2,
    FOFC_ACC_ZERO_G = 2'h3
  } fofc_acc_target_t;

  // Clock rate and millisecond tick
  localparam int FOFC_CLK_HZ = 100_000_000;
  localparam int FOFC_MS_PER_S = 1000;
  localparam int FOFC_CLK_PER_MS = FOFC_CLK_HZ / FOFC_MS_PER_S;
endpackage

/* tb/fofc_config_tb.sv */
// Self-checking bench for the flat and offset compensation bank
`timescale 1ns/10ps
module fofc_config_tb;
  import fofc_pkg::*;
  localparam int CPM = 4;
  localparam int LIMIT = 12000;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic flat_state = 1'b0;
  logic [FOFC_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] flat_theta;
  logic [2:0] level_hysteresis;
  logic [1:0] flat_hold_code;
  logic flat_int;
  logic [2:0] gyr_comp_en;
  logic [2:0] acc_comp_en;
  logic [2:0] acc_target_plus;
  logic [2:0] acc_target_minus;
  int mismatches = 0;
  int checked = 0;

  // Free-running system clock
  always #5 clk_sys = ~clk_sys;

  // Short millisecond so the longest hold fits the run
  fofc_config #(.CLK_PER_MS(CPM)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flat_state(flat_state), .flat_theta(flat_theta), .level_hysteresis(level_hysteresis),
    .flat_hold_code(flat_hold_code), .flat_int(flat_int), .gyr_comp_en(gyr_comp_en),
    .acc_comp_en(acc_comp_en), .acc_target_plus(acc_target_plus),
    .acc_target_minus(acc_target_minus));

  fofc_host_model host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // Verdict and end of run
  task automatic close_out();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Single compare point, four-state exact
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus access by register index; a hung bus ends the run
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] q);
    bit ok;
    host.xfer(w, {idx, 2'b00}, d, be, q, ok);
    if (!ok) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, 4'h1, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    check(q, exp);
  endtask

  // Reset values in registers and on the field outputs
  task automatic t_reset();
    rd_chk(FOFC_IDX_FLAT_THRESHOLD, 32'h0000_0008);
    rd_chk(FOFC_IDX_FLAT_HOLD_HYST, 32'h0000_0011);
    rd_chk(FOFC_IDX_OFFSET_COMP, 32'h0000_0000);
    check(32'(flat_theta), 32'h0000_0008);
    check(32'(flat_hold_code), 32'h0000_0001);
    check(32'(level_hysteresis), 32'h0000_0001);
    check(32'({gyr_comp_en, acc_comp_en, acc_target_plus, acc_target_minus}), 0);
  endtask

  // Flat bytes: full-scale angle, hold and hysteresis, masked and stray writes
  task automatic t_flat_regs();
    logic [31:0] q;
    wr(FOFC_IDX_FLAT_THRESHOLD, 8'h3F);
    wr(FOFC_IDX_FLAT_HOLD_HYST, 8'h26);
    rd_chk(FOFC_IDX_FLAT_THRESHOLD, 32'h0000_003F);
    rd_chk(FOFC_IDX_FLAT_HOLD_HYST, 32'h0000_0026);
    check(32'(flat_theta), 32'h0000_003F);
    check(32'(flat_hold_code), 32'h0000_0002);
    check(32'(level_hysteresis), 32'h0000_0006);
    bus(1'b1, FOFC_IDX_FLAT_THRESHOLD, 8'h05, 4'h0, q);
    wr(8'h6A, 8'h15);
    rd_chk(8'h6A, 32'h0000_0000);
    rd_chk(FOFC_IDX_FLAT_THRESHOLD, 32'h0000_003F);
    rd_chk(FOFC_IDX_OFFSET_COMP, 32'h0000_0000);
  endtask

  // Every target code on every axis, gyro enable both ways
  task automatic t_comp();
    logic [7:0] d;
    logic [1:0] cd;
    logic [2:0] en;
    logic [2:0] pl;
    logic [2:0] mn;
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        d = {1'b0, g[0], c[1:0], 2'(c + 1), 2'(c + 2)};
        for (int i = 0; i < 3; i++) begin
          cd = d[2*i +: 2];
          en[i] = (cd != 2'b00);
          pl[i] = (cd == 2'b01);
          mn[i] = (cd == 2'b10);
        end
        wr(FOFC_IDX_OFFSET_COMP, d);
        rd_chk(FOFC_IDX_OFFSET_COMP, 32'(d));
        check(32'(gyr_comp_en), 32'({3{g[0]}}));
        check(32'(acc_comp_en), 32'(en));
        check(32'(acc_target_plus), 32'(pl));
        check(32'(acc_target_minus), 32'(mn));
      end
    end
    wr(FOFC_IDX_OFFSET_COMP, 8'h00);
  endtask

  // Each hold code: pulse no sooner than the hold time and not much later
  task automatic t_hold();
    int ms[4] = '{0, 640, 1280, 2560};
    int n;
    int lo;
    bit seen;
    for (int c = 0; c < 4; c++) begin
      wr(FOFC_IDX_FLAT_HOLD_HYST, {2'b00, c[1:0], 4'h1});
      lo = ms[c] * CPM;
      n = 0;
      seen = 1'b0;
      @(posedge clk_sys);
      flat_state <= ~flat_state;
      while (!seen && n < LIMIT) begin
        @(negedge clk_sys);
        if (flat_int === 1'b1) begin
          seen = 1'b1;
        end else begin
          n++;
        end
      end
      check(32'(seen), 32'h0000_0001);
      check(32'(n >= lo && n <= lo + CPM + 4), 32'h0000_0001);
      if (!seen) begin
        close_out();
      end
      rd_chk(FOFC_IDX_FLAT_STATUS, 32'(flat_state));
    end
  endtask

  // Main sequence, with a second reset after the hold test, then the reset values checked again
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_flat_regs();
    t_comp();
    t_hold();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    close_out();
  end
endmodule

/* tb/fofc_host_model.sv */
// Host-side Avalon-MM master model for the configuration bank
`timescale 1ns/10ps
module fofc_host_model
  import fofc_pkg::*;
(
  input wire logic clk_sys,
  output logic [FOFC_ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  localparam int WAIT_MAX = 50;

  // Bus idle from time zero
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h5A5A_5A5A;
    avs_byteenable = 4'h0;
  end

  // One transfer; held until waitrequest is seen low, bounded so a hang is caught
  task automatic xfer(input logic wr, input logic [FOFC_ADDR_W-1:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [31:0] q, output bit ok);
    int n;
    ok = 1'b0;
    q = '0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d}; // Callers keep reserved bits zero
    avs_byteenable <= be;
    for (n = 0; n < WAIT_MAX && !ok; n++) begin
      // Sample at the edge itself; the reply only moves after it
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) begin
        q = avs_readdata;
        ok = 1'b1;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~avs_writedata; // Released data shows no stale value
  endtask
endmodule
